//--- hw/lmrc_ctrl.sv
// Purpose: Local memory and register controller, classic Wishbone slave
// Assumes: Single clock, synchronous active-high reset
// Notes:   SDRAM is outside, header storage sits in u_hdr; this block paces and decodes
// Behaviour
// RULE1: Header RAM bursts 64 bytes, 2-1 writes, 3-1 reads
// RULE2: Controller moves header bytes into random storage itself
// RULE3: Software initialises write mask before header RAM use
// RULE4: SDRAM 8 MB, 1 kB bursts, 1-0 writes, 2-0 reads
// RULE5: Bank holds release, pause, mask, clear, enable, mode, status
// RULE6: Status and error read via gated front-end enables
// RULE7: Registers 8 bits, one per aligned word
// RULE8: Any reset selects non-pedestal mode, clears logic
// RULE9: Busy output disabled after reset until enabled
// RULE10: Reset clears release and pause flags, front end
// RULE11: Host writes mask-init with all ones
// RULE12: Fixed decode: SDRAM zero, header, register bank
// RULE13: Header byte in low byte of each word
// RULE14: Release write clears own slot, read shows all
// RULE15: Clear write or last release pulses front-end reset
// RULE16: Undefined bits read zero, writes ignored
// RULE17: Unmapped accesses still acknowledged
module lmrc_ctrl
  import lmrc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // SDRAM side
  output logic             sdram_cs_o,
  output logic      [22:0] mem_adr_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_wdat_o,
  input  wire logic [31:0] sdram_rdat_i,
  // Header serial side
  input  wire logic        ser_stb_i,
  input  wire logic [7:0]  ser_data_i,
  // Header RAM mask strobe
  output logic             mask_wr_o,
  output logic      [7:0]  mask_dat_o,
  // Front end
  input  wire logic        start_data_i,
  input  wire logic        fe_busy_i,
  input  wire logic [7:0]  fe_dat_i,
  output logic      [1:0]  fe_oe_o,
  output logic             fe_clr_o,
  output logic             pedestal_mode_o,
  output logic             busy_o,
  output logic             hdr_full_o
);
  `include "lmrc_map.svh"
  // ==========================================================
  // Decoding helpers
  function automatic lmrc_target_e decode(input logic [31:0] a);
    if (a < `LMRC_SDRAM_TOP) begin
      decode = LMRC_T_SDRAM;                                // RULE12
    end else if (a >= `LMRC_VRAM_BASE && a < `LMRC_VRAM_BASE + `LMRC_VRAM_SPAN) begin
      decode = LMRC_T_VRAM;                                 // RULE12
    end else if (a >= `LMRC_REG_BASE && a < `LMRC_REG_BASE + `LMRC_REG_SPAN) begin
      decode = LMRC_T_REG;                                  // RULE12
    end else begin
      decode = LMRC_T_NONE;
    end
  endfunction : decode

  // Slot number addressed by a release or pause offset
  function automatic logic [1:0] slot_of(input logic [5:0] off);
    slot_of = off[3:2];
  endfunction : slot_of

  // ==========================================================
  // Sequencer and header mover
  lmrc_wait_if  wif ();
  lmrc_wait_seq u_wait (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .w     (wif)
  );

  logic [7:0] hdr_byte;
  logic       hdr_full;
  logic       fe_clr_d, fe_clr_q;
  lmrc_hdr_move #(
    .NBYTES (64)
  ) u_hdr (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ser_stb_i  (ser_stb_i),
    .ser_data_i (ser_data_i),
    .fe_clr_i   (fe_clr_q),
    .rd_idx_i   (adr_i[7:2]),                               // RULE13
    .rd_data_o  (hdr_byte),
    .full_o     (hdr_full)
  );

  // ==========================================================
  // Register state
  lmrc_target_e tgt;                       // Decoded region of request
  logic [5:0]   off;                       // Offset in register bank
  logic         req;                       // Live request
  logic         burst_q, burst_d;          // A beat already acked in cycle
  logic [2:0]   rel_q, rel_d;              // Busy-release flags
  logic [2:0]   pause_q, pause_d;          // Soft-pause flags
  logic         mode_q, mode_d;            // Pedestal detector mode
  logic         ben_q, ben_d;              // Busy output enable
  logic         ack_q, ack_d;
  logic [31:0]  dat_q, dat_d;
  logic         busy_q, busy_d;
  logic         mask_q, mask_d;
  logic [7:0]   mdat_q, mdat_d;
  logic [1:0]   oe_q, oe_d;
  logic         reg_wr, reg_rd;

  assign tgt    = decode(adr_i);
  assign off    = adr_i[5:0];
  assign req    = cyc_i && stb_i && !ack_q;
  assign reg_wr = req && we_i && tgt == LMRC_T_REG;
  assign reg_rd = req && !we_i && tgt == LMRC_T_REG;

  // Memory beats go through the wait sequencer; front-end status and error reads wait one cycle; others answer at once
  assign wif.req   = req && (tgt == LMRC_T_SDRAM || tgt == LMRC_T_VRAM);
  assign wif.we    = we_i;
  assign wif.first = !burst_q;
  assign wif.tgt   = tgt;

  // ==========================================================
  // Next-state logic for bank and bus answer
  always_comb begin
    rel_d    = rel_q;
    pause_d  = pause_q;
    mode_d   = mode_q;
    ben_d    = ben_q;
    ack_d    = 1'b0;
    dat_d    = 32'h0000_0000;
    fe_clr_d = 1'b0;
    mask_d   = 1'b0;
    mdat_d   = mdat_q;
    oe_d     = `LMRC_FEOE_NONE;
    burst_d  = burst_q && cyc_i;
    // Gate front-end read enables while a status or error read is pending
    if (reg_rd && off == `LMRC_OFF_FESTAT) begin
      oe_d = `LMRC_FEOE_STAT;                               // RULE6
    end else if (reg_rd && off == `LMRC_OFF_FEERR) begin
      oe_d = `LMRC_FEOE_ERR;                                // RULE6
    end
    if (wif.done) begin
      ack_d   = 1'b1;
      burst_d = 1'b1;
      if (tgt == LMRC_T_VRAM) begin
        dat_d = {24'h00_0000, hdr_byte};                    // RULE13
      end else begin
        dat_d = sdram_rdat_i;
      end
    end else if (req && tgt == LMRC_T_REG) begin
      // Front-end reads wait one cycle for the gated enable
      if (!reg_rd || oe_q != `LMRC_FEOE_NONE ||
          (off != `LMRC_OFF_FESTAT && off != `LMRC_OFF_FEERR)) begin
        ack_d = 1'b1;
      end
      if (reg_wr) begin
        case (off)
          `LMRC_OFF_REL0, `LMRC_OFF_REL1, `LMRC_OFF_REL2: begin
            rel_d[slot_of(off)] = 1'b0;                     // RULE14
            if (rel_q != 3'h0 && (rel_q & ~(3'h1 << slot_of(off))) == 3'h0) begin
              fe_clr_d = 1'b1;                              // RULE15
            end
          end
          `LMRC_OFF_PAUSE0, `LMRC_OFF_PAUSE1, `LMRC_OFF_PAUSE2: begin // RULE5
            pause_d[slot_of(off)] = dat_i[slot_of(off)];
          end
          `LMRC_OFF_FECLR:    fe_clr_d = 1'b1;              // RULE15
          `LMRC_OFF_MODE:     mode_d = dat_i[0];            // RULE16
          `LMRC_OFF_BUSYEN:   ben_d = dat_i[0];             // RULE9
          `LMRC_OFF_MASKINIT: begin
            mask_d = 1'b1;
            mdat_d = dat_i[7:0];                            // RULE7
          end
          default: ;
        endcase
      end else begin
        case (off)
          `LMRC_OFF_REL0, `LMRC_OFF_REL1, `LMRC_OFF_REL2:
            dat_d = {29'h0000_0000, rel_q};                 // RULE14
          `LMRC_OFF_PAUSE0, `LMRC_OFF_PAUSE1, `LMRC_OFF_PAUSE2:
            dat_d = {29'h0000_0000, pause_q};
          `LMRC_OFF_FESTAT, `LMRC_OFF_FEERR:
            dat_d = {24'h00_0000, fe_dat_i};                // RULE6
          `LMRC_OFF_MODE:   dat_d = {31'h0000_0000, mode_q};   // RULE16
          `LMRC_OFF_BUSYEN: dat_d = {31'h0000_0000, ben_q};
          default:          dat_d = 32'h0000_0000;          // RULE16
        endcase
      end
    end else if (req && tgt == LMRC_T_NONE) begin
      ack_d = 1'b1;                                         // RULE17
    end
    // Start of data marks every slot busy; it wins over a release
    if (start_data_i) begin
      rel_d = 3'h7;
    end
    busy_d = ben_d && (fe_busy_i || rel_d != 3'h0 || pause_d != 3'h0); // RULE9
  end

  // ==========================================================
  // Registers; any reset restores defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_q    <= `LMRC_RST_FLAGS;                          // RULE10
      pause_q  <= `LMRC_RST_FLAGS;                          // RULE10
      mode_q   <= `LMRC_RST_MODE;                           // RULE8
      ben_q    <= `LMRC_RST_BUSYEN;                         // RULE9
      ack_q    <= 1'b0;
      dat_q    <= 32'h0000_0000;
      fe_clr_q <= 1'b1;                                     // RULE10
      busy_q   <= 1'b0;
      mask_q   <= 1'b0;
      mdat_q   <= 8'h00;
      oe_q     <= `LMRC_FEOE_NONE;
      burst_q  <= 1'b0;
    end else begin
      rel_q    <= rel_d;
      pause_q  <= pause_d;
      mode_q   <= mode_d;
      ben_q    <= ben_d;
      ack_q    <= ack_d;
      dat_q    <= dat_d;
      fe_clr_q <= fe_clr_d;
      busy_q   <= busy_d;
      mask_q   <= mask_d;
      mdat_q   <= mdat_d;
      oe_q     <= oe_d;
      burst_q  <= burst_d;
    end
  end

  // Memory strobes follow the live request, registered
  logic        scs_q;
  logic [22:0] madr_q;
  logic        mwe_q;
  logic [31:0] mwd_q;
  logic        hfull_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scs_q   <= 1'b0;
      madr_q  <= 23'h00_0000;
      mwe_q   <= 1'b0;
      mwd_q   <= 32'h0000_0000;
      hfull_q <= 1'b0;
    end else begin
      scs_q   <= req && tgt == LMRC_T_SDRAM;                // RULE4
      madr_q  <= adr_i[22:0];
      mwe_q   <= req && we_i && tgt == LMRC_T_SDRAM;
      mwd_q   <= dat_i;
      hfull_q <= hdr_full;
    end
  end

  assign ack_o           = ack_q;
  assign dat_o           = dat_q;
  assign sdram_cs_o      = scs_q;
  assign mem_adr_o       = madr_q;
  assign mem_we_o        = mwe_q;
  assign mem_wdat_o      = mwd_q;
  assign mask_wr_o       = mask_q;
  assign mask_dat_o      = mdat_q;
  assign fe_oe_o         = oe_q;
  assign fe_clr_o        = fe_clr_q;
  assign pedestal_mode_o = mode_q;
  assign busy_o          = busy_q;
  assign hdr_full_o      = hfull_q;

  // ==========================================================
  // Checks
  sequence s_clr_write;
    reg_wr && off == `LMRC_OFF_FECLR;
  endsequence
  a_clear_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
    s_clr_write |=> fe_clr_o) else $error("front-end clear missing");
  a_busy_gated: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    !ben_q && !(reg_wr && off == `LMRC_OFF_BUSYEN) |=> !busy_o)
    else $error("busy output while disabled");
  a_unmapped_ack: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
    req && tgt == LMRC_T_NONE |=> ack_o) else $error("unmapped access not acked");
  a_release_own: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    reg_wr && off == `LMRC_OFF_REL1 && !start_data_i |=> !rel_q[1])
    else $error("release did not clear slot");
  a_reset_mode: assert property (@(posedge clk_i) // RULE8
    rst_i |=> !pedestal_mode_o && !busy_o && rel_q == 3'h0 && pause_q == 3'h0)
    else $error("reset defaults wrong");
  a_vram_rd_wait: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    $rose(wif.req) && tgt == LMRC_T_VRAM && !we_i && !burst_q |-> !ack_o [*5])
    else $error("header read answered early");
  a_sdram_wr_wait: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    $rose(wif.req) && tgt == LMRC_T_SDRAM && we_i && !burst_q |-> ##3 ack_o)
    else $error("SDRAM write timing wrong");
  a_hdr_low_byte: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    ack_o && $past(tgt) == LMRC_T_VRAM && !$past(we_i) |-> dat_o[31:8] == 24'h00_0000)
    else $error("header upper bytes not zero");
endmodule : lmrc_ctrl

//--- hw/lmrc_hdr_move.sv
// Purpose: Moves header bytes from the serial side into random storage
// Assumes: Header bytes arrive one per strobe
// Notes:   Runs without any software action
module lmrc_hdr_move
  import lmrc_pkg::*;
#(
  parameter int NBYTES = 64
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Serial side
  input  wire logic       ser_stb_i,
  input  wire logic [7:0] ser_data_i,
  input  wire logic       fe_clr_i,
  // Random read port
  input  wire logic [5:0] rd_idx_i,
  output logic      [7:0] rd_data_o,
  output logic            full_o
);
  // ==========================================================
  // Random storage, written by the mover only
  logic [7:0] mem_q [NBYTES];
  lmrc_hdr_e  st_q, st_d;
  logic [5:0] wp_q, wp_d;
  logic       wen;

  // Next state; a front-end clear rearms for the next event
  always_comb begin
    st_d = st_q;
    wp_d = wp_q;
    wen  = 1'b0;
    case (st_q)
      LMRC_H_IDLE, LMRC_H_MOVE: begin
        if (ser_stb_i) begin
          wen  = 1'b1;                       // RULE2
          wp_d = wp_q + 6'h1;
          st_d = (wp_q == 6'(NBYTES - 1)) ? LMRC_H_DONE : LMRC_H_MOVE;
        end
      end
      LMRC_H_DONE: ;
      default: st_d = LMRC_H_IDLE;
    endcase
    if (fe_clr_i) begin
      st_d = LMRC_H_IDLE;
      wp_d = 6'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= LMRC_H_IDLE;
      wp_q <= 6'h0;
    end else begin
      st_q <= st_d;
      wp_q <= wp_d;
    end
    if (wen) begin
      mem_q[wp_q] <= ser_data_i;
    end
  end

  assign rd_data_o = mem_q[rd_idx_i];
  assign full_o    = (st_q == LMRC_H_DONE);
endmodule : lmrc_hdr_move

//--- hw/lmrc_map.svh
// Purpose: Address map, field positions, reset values and timing counts
// Assumes: Included by the controller package users
// Notes:   Definitions only
`ifndef LMRC_MAP_SVH
`define LMRC_MAP_SVH
// ==========================================================
// Region bases and sizes (byte addresses)
`define LMRC_SDRAM_BASE     32'h0000_0000
`define LMRC_SDRAM_TOP      32'h0080_0000
`define LMRC_VRAM_BASE      32'h0080_0000
`define LMRC_VRAM_SPAN      32'h0000_0100
`define LMRC_REG_BASE       32'h0080_8000
`define LMRC_REG_SPAN       32'h0000_0040
// ==========================================================
// Register offsets within the register bank
`define LMRC_OFF_REL0       6'h00
`define LMRC_OFF_REL1       6'h04
`define LMRC_OFF_REL2       6'h08
`define LMRC_OFF_PAUSE0     6'h10
`define LMRC_OFF_PAUSE1     6'h14
`define LMRC_OFF_PAUSE2     6'h18
`define LMRC_OFF_FECLR      6'h20
`define LMRC_OFF_FESTAT     6'h24
`define LMRC_OFF_FEERR      6'h28
`define LMRC_OFF_MODE       6'h2C
`define LMRC_OFF_MASKINIT   6'h30
`define LMRC_OFF_BUSYEN     6'h34
// ==========================================================
// Reset values
`define LMRC_RST_MODE       1'b0
`define LMRC_RST_BUSYEN     1'b0
`define LMRC_RST_FLAGS      3'h0
// ==========================================================
// Front-end gate codes
`define LMRC_FEOE_NONE      2'h0
`define LMRC_FEOE_STAT      2'h1
`define LMRC_FEOE_ERR       2'h2
// ==========================================================
// Wait states per beat
`define LMRC_VW_FIRST       4'h2
`define LMRC_VR_FIRST       4'h3
`define LMRC_V_NEXT         4'h1
`define LMRC_SW_FIRST       4'h1
`define LMRC_SR_FIRST       4'h2
`define LMRC_S_NEXT         4'h0
`define LMRC_VRAM_BURST     7'h40
`define LMRC_SDRAM_BURST    11'h400
// ==========================================================
// Header move
`define LMRC_HDR_BYTES      7'h40
`endif

//--- hw/lmrc_pkg.sv
// Purpose: Types shared by the controller modules
// Assumes: None
// Notes:   Constants live in lmrc_map.svh
package lmrc_pkg;
  // ==========================================================
  // Decoded target of a bus access
  typedef enum logic [1:0] {
    LMRC_T_NONE,
    LMRC_T_SDRAM,
    LMRC_T_VRAM,
    LMRC_T_REG
  } lmrc_target_e;
  // Wait-state sequencer states
  typedef enum logic [1:0] {
    LMRC_W_IDLE,
    LMRC_W_WAIT,
    LMRC_W_ACK
  } lmrc_wait_e;
  // Header move states
  typedef enum logic [1:0] {
    LMRC_H_IDLE,
    LMRC_H_MOVE,
    LMRC_H_DONE
  } lmrc_hdr_e;
endpackage : lmrc_pkg

//--- hw/lmrc_wait_if.sv
// Purpose: Request and answer between bus front and wait-state sequencer
// Assumes: One clock
// Notes:   first marks the first beat of a burst
interface lmrc_wait_if;
  import lmrc_pkg::*;
  logic         req;    // Beat requested
  logic         we;     // Beat is a write
  logic         first;  // First beat of a burst
  lmrc_target_e tgt;    // Addressed region
  logic         done;   // Beat may be acknowledged
  modport master (output req, we, first, tgt, input done);
  modport slave  (input req, we, first, tgt, output done);
endinterface : lmrc_wait_if

//--- hw/lmrc_wait_seq.sv
// Purpose: Wait-state sequencer for memory beats
// Assumes: Request held until done
// Notes:   Registers answer in zero wait states, front-end status and error reads in one
module lmrc_wait_seq
  import lmrc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Sequencer port
  lmrc_wait_if.slave w
);
  `include "lmrc_map.svh"
  // ==========================================================
  // Wait count per beat, by region, direction and position
  function automatic logic [3:0] waits(input lmrc_target_e t, input logic wr,
                                       input logic fst);
    if (t == LMRC_T_VRAM) begin
      waits = fst ? (wr ? `LMRC_VW_FIRST : `LMRC_VR_FIRST) : `LMRC_V_NEXT; // RULE1
    end else if (t == LMRC_T_SDRAM) begin
      waits = fst ? (wr ? `LMRC_SW_FIRST : `LMRC_SR_FIRST) : `LMRC_S_NEXT; // RULE4
    end else begin
      waits = 4'h0;
    end
  endfunction : waits

  lmrc_wait_e st_q, st_d;     // Sequencer state
  logic [3:0] cnt_q, cnt_d;   // Remaining wait states

  // Next state
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    w.done = 1'b0;
    case (st_q)
      LMRC_W_IDLE: begin
        if (w.req) begin
          cnt_d = waits(w.tgt, w.we, w.first);
          st_d  = (cnt_d == 4'h0) ? LMRC_W_ACK : LMRC_W_WAIT;
        end
      end
      LMRC_W_WAIT: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          st_d = LMRC_W_ACK;
        end
      end
      LMRC_W_ACK: begin
        // One done pulse, then straight back to idle for the next beat
        w.done = 1'b1;
        st_d   = LMRC_W_IDLE;
      end
      default: st_d = LMRC_W_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= LMRC_W_IDLE;
      cnt_q <= 4'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : lmrc_wait_seq

//--- verification/lmrc_ctrl_test.sv
// Purpose: Self-checking bench for the local memory and register controller
// Assumes: Classic single Wishbone cycles, 40 MHz clock
// Notes:   Latencies counted in cycles after the taking edge
`include "lmrc_map.svh"
module lmrc_ctrl_test
  import lmrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, wdat = 0, dat_o, sd_rdat, q;
  logic        ack_o, sd_cs, mem_we, mask_wr, fe_clr, ped, busy, full;
  logic        ser_stb = 0, start = 0;
  logic [7:0]  ser_dat = 0, fe_dat, mask_dat, mask_last = 0;
  logic [22:0] mem_adr, wa_last = 0;
  logic [31:0] mem_wdat, wd_last = 0;
  logic [1:0]  fe_oe;
  int          n_errors = 0, n_checks = 0, n_clr = 0, k, c0;
  logic [2:0]  m;
  // ==========================================================
  // Clock, pulse monitors
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (fe_clr === 1'b1) n_clr++;
    if (mask_wr === 1'b1) mask_last = mask_dat;
    // Last SDRAM write strobe, address and data
    if (mem_we === 1'b1) begin
      wd_last = mem_wdat;
      wa_last = mem_adr;
    end
  end
  lmrc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .sdram_cs_o(sd_cs), .mem_adr_o(mem_adr), .mem_we_o(mem_we), .mem_wdat_o(mem_wdat),
    .sdram_rdat_i(sd_rdat), .ser_stb_i(ser_stb), .ser_data_i(ser_dat),
    .mask_wr_o(mask_wr), .mask_dat_o(mask_dat), .start_data_i(start), .fe_busy_i(1'b0),
    .fe_dat_i(fe_dat), .fe_oe_o(fe_oe), .fe_clr_o(fe_clr), .pedestal_mode_o(ped),
    .busy_o(busy), .hdr_full_o(full));
  lmrc_far_model far (.clk_i(clk_i), .fe_oe_i(fe_oe), .sdram_cs_i(sd_cs),
    .mem_adr_i(mem_adr), .fe_dat_o(fe_dat), .sdram_rdat_o(sd_rdat));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] ra(input logic [5:0] o);
    return `LMRC_REG_BASE + {26'h0, o};
  endfunction : ra
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; a gap cycle comes first so stb is low between cycles
  // No cycle limit here: only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    k = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
      k++;
    end
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask : wb
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdc
  task automatic pulse_start();
    @(posedge clk_i) start <= 1;
    @(posedge clk_i) start <= 0;
  endtask : pulse_start
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rdc(ra(`LMRC_OFF_MODE), 0);
    rdc(ra(`LMRC_OFF_BUSYEN), 0);
    rdc(ra(`LMRC_OFF_REL0), 0);
    rdc(ra(`LMRC_OFF_PAUSE0), 0);
    wb(1, ra(`LMRC_OFF_BUSYEN), 32'hFFFF_FFFF);
    rdc(ra(`LMRC_OFF_BUSYEN), 1);
    // Release flags: each write clears its own slot, the last one clears the front end
    pulse_start();
    rdc(ra(`LMRC_OFF_REL2), 7);
    chk(32'(busy), 1);
    c0 = n_clr;
    m = 3'h7;
    for (int s = 0; s < 3; s++) begin
      wb(1, ra(`LMRC_OFF_REL0 + 6'(4 * s)), 32'h0);
      m[s] = 1'b0;
      rdc(ra(`LMRC_OFF_REL0), 32'(m));
    end
    repeat (3) @(posedge clk_i);
    chk(n_clr - c0, 1);
    chk(32'(busy), 0);
    // Pause flags set and cleared per slot
    for (int s = 0; s < 3; s++) begin
      wb(1, ra(`LMRC_OFF_PAUSE0 + 6'(4 * s)), 32'(1 << s));
      rdc(ra(`LMRC_OFF_PAUSE1), 32'((2 << s) - 1));
    end
    chk(32'(busy), 1);
    for (int s = 0; s < 3; s++) wb(1, ra(`LMRC_OFF_PAUSE0 + 6'(4 * s)), 32'h0);
    rdc(ra(`LMRC_OFF_PAUSE2), 0);
    c0 = n_clr;
    wb(1, ra(`LMRC_OFF_FECLR), 32'h0);
    repeat (3) @(posedge clk_i);
    chk(n_clr - c0, 1);
    wb(1, ra(`LMRC_OFF_MODE), 32'h0000_0101);
    chk(32'(ped), 1);
    rdc(ra(`LMRC_OFF_MODE), 1);
    rdc(ra(`LMRC_OFF_FESTAT), 32'hA5);
    chk(k, 2);
    rdc(ra(`LMRC_OFF_FEERR), 32'h3C);
    wb(1, ra(`LMRC_OFF_MASKINIT), 32'h0000_00FF);
    repeat (2) @(posedge clk_i);
    chk(32'(mask_last), 32'hFF);
    rdc(32'h0100_0000, 0);
    chk(k, 1);
    rdc(ra(6'h3C), 0);
    // SDRAM single beats: a write low in the region and a read of its last word
    wb(1, 32'h0000_1234, 32'hCAFE_0001);
    chk(k, 3);
    chk(wd_last, 32'hCAFE_0001);
    chk(32'(wa_last), 32'h0000_1234);
    rdc(32'h007F_FFFC, 32'h5A5A_0000 ^ 32'h007F_FFFC);
    chk(k, 4);
    // Header bytes arrive serially and are moved without software help
    chk(32'(full), 0);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_i);
      ser_stb <= 1;
      ser_dat <= 8'(i) ^ 8'hC3;
    end
    @(posedge clk_i) ser_stb <= 0;
    repeat (3) @(posedge clk_i);
    chk(32'(full), 1);
    for (int i = 0; i < 64; i++) begin
      rdc(`LMRC_VRAM_BASE + 32'(4 * i), 32'(8'(i) ^ 8'hC3));
      chk(k, 5);
    end
    wb(1, `LMRC_VRAM_BASE + 32'h0000_00FC, 32'h0000_0011);
    chk(k, 4);
    // Reset in mid-run restores every default
    pulse_start();
    wb(1, ra(`LMRC_OFF_PAUSE0), 32'h1);
    c0 = n_clr;
    @(posedge clk_i) rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rdc(ra(`LMRC_OFF_REL1), 0);
    chk(n_clr - c0, 2);
    rdc(ra(`LMRC_OFF_PAUSE0), 0);
    rdc(ra(`LMRC_OFF_MODE), 0);
    rdc(ra(`LMRC_OFF_BUSYEN), 0);
    chk(32'(ped), 0);
    // Start of data while disabled must not reach the busy output
    pulse_start();
    repeat (2) @(posedge clk_i);
    chk(32'(busy), 0);
    close_out();
  end
endmodule : lmrc_ctrl_test

//--- verification/lmrc_far_model.sv
// Purpose: Front-end register file and SDRAM data source facing the controller
// Assumes: One clock; gates and chip select come from the controller
// Notes:   Unselected data lines change every cycle so stale values never match
module lmrc_far_model (
  // Clock
  input  wire logic        clk_i,
  // Controller side
  input  wire logic [1:0]  fe_oe_i,
  input  wire logic        sdram_cs_i,
  input  wire logic [22:0] mem_adr_i,
  // Data back to controller
  output logic      [7:0]  fe_dat_o,
  output logic      [31:0] sdram_rdat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic             flip_q; // Toggles each cycle for undriven lines
  // ==========================================================
  // Idle pattern
  always @(posedge clk_i) flip_q <= (flip_q === 1'b1) ? 1'b0 : 1'b1;
  // ==========================================================
  // Gated front-end registers; any other gate drives the toggling idle pattern
  always_comb begin
    case (fe_oe_i)
      2'h1:    fe_dat_o = 8'hA5;
      2'h2:    fe_dat_o = 8'h3C;
      default: fe_dat_o = {8{flip_q}};
    endcase
  end
  // ==========================================================
  // SDRAM answers an address-derived word only while selected
  assign sdram_rdat_o = sdram_cs_i ? ({9'h0, mem_adr_i} ^ 32'h5A5A_0000) : {32{flip_q}};
endmodule : lmrc_far_model
